// ### include/arith_params.svh
// Offsets, field positions, reset values and timing counts of the arithmetic block
`ifndef ARITH_PARAMS_SVH
`define ARITH_PARAMS_SVH

`define OFS_FLAGS 12'h000
`define OFS_IRQ_STATUS 12'h004
`define OFS_IRQ_ENABLE 12'h008
`define OFS_IRQ_CLEAR 12'h00C
`define OFS_UNIT_BASE 12'h100
`define UNIT_OFS_MODE 4'h0
`define UNIT_OFS_OPA 4'h4
`define UNIT_OFS_OPB 4'h8
`define UNIT_OFS_RESULT 4'hC
`define FLD_MODE_LSB 0
`define FLD_MODE_W 2
`define FLD_NULL_LSB 16
`define RST_WORD 32'h0000_0000
`define RST_MODE 2'h0
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define CLK_PERIOD_NS 40
`define SCAN_TIME_NS 1000
`define SCAN_CYCLES (`SCAN_TIME_NS / `CLK_PERIOD_NS)

`endif

// ### include/arith_pkg.sv
// Types shared by the arithmetic block files
package arith_pkg;
   typedef enum logic [1:0] {MODE_ADD, MODE_SUB, MODE_MUL, MODE_DIV} calc_mode_type;
   typedef enum logic {WR_IDLE, WR_RESP} wr_state_type;
   typedef enum logic {RD_IDLE, RD_RESP} rd_state_type;
   typedef enum logic [3:0] {
      REG_FLAGS, REG_IRQ_STATUS, REG_IRQ_ENABLE, REG_IRQ_CLEAR,
      REG_MODE, REG_OPA, REG_OPB, REG_RESULT, REG_NONE
   } reg_kind_type;
endpackage

// ### rtl/calc_unit.sv
// One signed 32-bit arithmetic unit evaluated on each scan strobe
`timescale 1ns/1ns
`default_nettype none
`include "arith_params.svh"
module calc_unit
   import arith_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Evaluation
   input wire logic scan_en,
   input wire calc_mode_type mode,
   input wire logic [31:0] operand_a,
   input wire logic [31:0] operand_b,
   // Results
   output logic [31:0] result_out,
   output logic overflow_flag,
   output logic null_result_flag,
   output logic overflow_event
);
   logic [31:0] result_q, result_d;
   logic ovf_q, ovf_d, null_q, null_d;
   logic signed [32:0] sum_w, diff_w;
   logic signed [63:0] prod_w;
   logic signed [31:0] quot_w;
   logic [31:0] value_w;
   logic ovf_w, div_bad_w;

   assign sum_w = {operand_a[31], operand_a} + {operand_b[31], operand_b};
   assign diff_w = {operand_a[31], operand_a} - {operand_b[31], operand_b};
   assign prod_w = $signed(operand_a) * $signed(operand_b);
   // Zero divisor and min/-1 both leave the 32-bit range
   assign div_bad_w = (operand_b == 32'h0000_0000) ||
      (operand_a == 32'h8000_0000 && operand_b == 32'hFFFF_FFFF);
   assign quot_w = div_bad_w ? 32'sh0000_0000 : $signed(operand_a) / $signed(operand_b);

   always_comb begin
      value_w = result_q;
      ovf_w = 1'b0;
      case (mode)
         MODE_ADD: begin
            value_w = sum_w[31:0];
            ovf_w = sum_w[32] != sum_w[31];
         end
         MODE_SUB: begin
            value_w = diff_w[31:0];
            ovf_w = diff_w[32] != diff_w[31];
         end
         MODE_MUL: begin
            value_w = prod_w[31:0];
            ovf_w = prod_w[63:32] != {32{prod_w[31]}};
         end
         default: begin
            value_w = quot_w;
            ovf_w = div_bad_w;
         end
      endcase
   end

   always_comb begin
      result_d = result_q;
      ovf_d = ovf_q;
      if (scan_en) begin
         ovf_d = ovf_w;
         if (!ovf_w) begin
            result_d = value_w;
         end
      end
      null_d = (result_d == 32'h0000_0000);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_q <= `RST_WORD;
         ovf_q <= 1'b0;
         null_q <= 1'b1;
      end else begin
         result_q <= result_d;
         ovf_q <= ovf_d;
         null_q <= null_d;
      end
   end

   assign result_out = result_q;
   assign overflow_flag = ovf_q;
   assign null_result_flag = null_q;
   assign overflow_event = scan_en & ovf_w;

   // Truncation toward zero: the remainder is below the divisor and follows the dividend
   function automatic logic trunc_ok(input logic [31:0] a, input logic [31:0] b,
                                     input logic [31:0] q);
      longint r;
      longint m;
      r = longint'($signed(a)) - longint'($signed(q)) * longint'($signed(b));
      m = longint'($signed(b));
      if (m < 0) begin
         m = -m;
      end
      if (r < 0) begin
         trunc_ok = a[31] && (-r < m);
      end else begin
         trunc_ok = (r == 0) || (!a[31] && r < m);
      end
   endfunction

   zero_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      null_result_flag == (result_out == 32'h0000_0000))
      else $error("zero flag disagrees with result");
   reset_clear_a: assert property (@(posedge aclk)
      !aresetn |=> result_out == 32'h0000_0000 && !overflow_flag)
      else $error("reset did not clear result");
   overflow_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_en && ovf_w |=> overflow_flag && result_out == $past(result_out))
      else $error("overflow did not hold last result");
   div_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_en && mode == MODE_DIV && operand_b == 32'h0000_0000 |=> overflow_flag)
      else $error("zero divisor did not flag overflow");
   div_trunc_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_en && mode == MODE_DIV && !div_bad_w |=>
      trunc_ok($past(operand_a), $past(operand_b), result_out) && !overflow_flag)
      else $error("division result wrong");
   idle_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !scan_en |=> $stable(result_out) && $stable(overflow_flag))
      else $error("result moved without scan strobe");
   add_valid_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_en && mode == MODE_ADD && !ovf_w |=>
      result_out == $past(operand_a) + $past(operand_b))
      else $error("sum wrong");
endmodule // calc_unit
`default_nettype wire

// ### rtl/arith_block.sv
// Bank of signed arithmetic units with an AXI4-Lite register slave
// Operation
// - Each unit adds, subtracts, multiplies or divides operand A by operand B as its mode says.
// - After reset every unit's mode is addition.
// - Operands are signed 32-bit two's-complement values.
// - The result is a signed 32-bit integer, never a fraction.
// - An out-of-range sum, difference or product raises overflow and keeps the old result.
// - The zero flag is high exactly while the result is zero.
// - The result reads zero before any valid operation.
// - Division truncates toward zero with ordinary sign rules.
// - A zero divisor counts as overflow and keeps the old result.
// - Units evaluate on every scan with no enable or start input.
// - Sixteen independent units each have their own mode, operands, result and flags.
`timescale 1ns/1ns
`default_nettype none
`include "arith_params.svh"
module arith_block
   import arith_pkg::*;
#(
   parameter int NUM_UNITS = 16,
   parameter int SCAN_CYCLES = `SCAN_CYCLES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Unit results
   output logic [NUM_UNITS-1:0][31:0] result_out,
   output logic [NUM_UNITS-1:0] overflow_flag,
   output logic [NUM_UNITS-1:0] null_result_flag,
   // Interrupt
   output logic irq
);
   // Scan divider
   logic [15:0] scan_cnt_q, scan_cnt_d;
   logic scan_en;

   // Register bank
   calc_mode_type mode_q [NUM_UNITS];
   calc_mode_type mode_d [NUM_UNITS];
   logic [31:0] opa_q [NUM_UNITS];
   logic [31:0] opa_d [NUM_UNITS];
   logic [31:0] opb_q [NUM_UNITS];
   logic [31:0] opb_d [NUM_UNITS];
   logic [NUM_UNITS-1:0] status_q, status_d, enable_q, enable_d;
   logic [NUM_UNITS-1:0] ovf_event;

   // Write channel
   wr_state_type wr_state_q, wr_state_d;
   logic aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [11:0] awaddr_q, awaddr_d, wr_addr;
   logic [31:0] wdata_q, wdata_d, wr_data;
   logic [3:0] wstrb_q, wstrb_d, wr_strb;
   logic [1:0] bresp_q, bresp_d;
   logic do_write;
   reg_kind_type wr_kind;
   logic [3:0] wr_unit;

   // Read channel
   rd_state_type rd_state_q, rd_state_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   reg_kind_type rd_kind;
   logic [3:0] rd_unit;

   // Unit bank sits at a 16-byte stride above the global registers
   function automatic reg_kind_type decode(input logic [11:0] addr);
      if (addr == `OFS_FLAGS) begin
         decode = REG_FLAGS;
      end else if (addr == `OFS_IRQ_STATUS) begin
         decode = REG_IRQ_STATUS;
      end else if (addr == `OFS_IRQ_ENABLE) begin
         decode = REG_IRQ_ENABLE;
      end else if (addr == `OFS_IRQ_CLEAR) begin
         decode = REG_IRQ_CLEAR;
      end else if (addr[11:8] != 4'(`OFS_UNIT_BASE >> 8) || 32'(addr[7:4]) >= NUM_UNITS) begin
         decode = REG_NONE;
      end else if (addr[3:0] == `UNIT_OFS_MODE) begin
         decode = REG_MODE;
      end else if (addr[3:0] == `UNIT_OFS_OPA) begin
         decode = REG_OPA;
      end else if (addr[3:0] == `UNIT_OFS_OPB) begin
         decode = REG_OPB;
      end else if (addr[3:0] == `UNIT_OFS_RESULT) begin
         decode = REG_RESULT;
      end else begin
         decode = REG_NONE;
      end
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merge[8*i +: 8] = data[8*i +: 8];
         end
      end
   endfunction

   // Free-running scan strobe; no start input exists
   always_comb begin
      scan_cnt_d = scan_cnt_q + 16'h0001;
      if (scan_cnt_q == 16'(SCAN_CYCLES - 1)) begin
         scan_cnt_d = 16'h0000;
      end
   end
   assign scan_en = (scan_cnt_q == 16'(SCAN_CYCLES - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_cnt_q <= 16'h0000;
      end else begin
         scan_cnt_q <= scan_cnt_d;
      end
   end

   // Units
   for (genvar gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
      calc_unit u_calc (
         .aclk(aclk),
         .aresetn(aresetn),
         .scan_en(scan_en),
         .mode(mode_q[gi]),
         .operand_a(opa_q[gi]),
         .operand_b(opb_q[gi]),
         .result_out(result_out[gi]),
         .overflow_flag(overflow_flag[gi]),
         .null_result_flag(null_result_flag[gi]),
         .overflow_event(ovf_event[gi])
      );
   end

   // Write channel: address and data are taken in either order
   always_comb begin
      wr_state_d = wr_state_q;
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bresp_d = bresp_q;
      awready = (wr_state_q == WR_IDLE) && !aw_held_q;
      wready = (wr_state_q == WR_IDLE) && !w_held_q;
      wr_addr = aw_held_q ? awaddr_q : awaddr;
      wr_data = w_held_q ? wdata_q : wdata;
      wr_strb = w_held_q ? wstrb_q : wstrb;
      do_write = (wr_state_q == WR_IDLE) && (aw_held_q || awvalid) && (w_held_q || wvalid);
      case (wr_state_q)
         WR_IDLE: begin
            if (do_write) begin
               wr_state_d = WR_RESP;
               aw_held_d = 1'b0;
               w_held_d = 1'b0;
               bresp_d = (decode(wr_addr) == REG_NONE) ? `RESP_DECERR : `RESP_OKAY;
            end else begin
               if (awvalid && awready) begin
                  aw_held_d = 1'b1;
                  awaddr_d = awaddr;
               end
               if (wvalid && wready) begin
                  w_held_d = 1'b1;
                  wdata_d = wdata;
                  wstrb_d = wstrb;
               end
            end
         end
         default: begin
            if (bready) begin
               wr_state_d = WR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= WR_IDLE;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= `RST_WORD;
         wstrb_q <= 4'h0;
         bresp_q <= `RESP_OKAY;
      end else begin
         wr_state_q <= wr_state_d;
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bresp_q <= bresp_d;
      end
   end

   assign bvalid = (wr_state_q == WR_RESP);
   assign bresp = bresp_q;

   // Register bank; a new overflow beats a clear in the same cycle
   assign wr_kind = decode(wr_addr);
   assign wr_unit = wr_addr[7:4];

   always_comb begin
      logic [31:0] clr;
      clr = `RST_WORD;
      mode_d = mode_q;
      opa_d = opa_q;
      opb_d = opb_q;
      enable_d = enable_q;
      if (do_write) begin
         if (wr_kind == REG_IRQ_ENABLE) begin
            enable_d = NUM_UNITS'(merge(32'(enable_q), wr_data, wr_strb));
         end else if (wr_kind == REG_IRQ_CLEAR) begin
            clr = merge(`RST_WORD, wr_data, wr_strb);
         end else if (wr_kind == REG_MODE && wr_strb[0]) begin
            mode_d[wr_unit] = calc_mode_type'(wr_data[`FLD_MODE_LSB +: `FLD_MODE_W]);
         end else if (wr_kind == REG_OPA) begin
            opa_d[wr_unit] = merge(opa_q[wr_unit], wr_data, wr_strb);
         end else if (wr_kind == REG_OPB) begin
            opb_d[wr_unit] = merge(opb_q[wr_unit], wr_data, wr_strb);
         end
      end
      status_d = (status_q & ~clr[NUM_UNITS-1:0]) | ovf_event;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_UNITS; i++) begin
            mode_q[i] <= calc_mode_type'(`RST_MODE);
            opa_q[i] <= `RST_WORD;
            opb_q[i] <= `RST_WORD;
         end
         status_q <= '0;
         enable_q <= '0;
      end else begin
         mode_q <= mode_d;
         opa_q <= opa_d;
         opb_q <= opb_d;
         status_q <= status_d;
         enable_q <= enable_d;
      end
   end

   assign irq = |(status_q & enable_q);

   // Read channel; unmapped addresses answer zero with a decode error
   assign rd_kind = decode(araddr);
   assign rd_unit = araddr[7:4];

   always_comb begin
      rd_state_d = rd_state_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      arready = (rd_state_q == RD_IDLE);
      case (rd_state_q)
         RD_IDLE: begin
            if (arvalid) begin
               rd_state_d = RD_RESP;
               rresp_d = `RESP_OKAY;
               rdata_d = `RST_WORD;
               if (rd_kind == REG_FLAGS) begin
                  rdata_d[NUM_UNITS-1:0] = overflow_flag;
                  rdata_d[`FLD_NULL_LSB +: NUM_UNITS] = null_result_flag;
               end else if (rd_kind == REG_IRQ_STATUS) begin
                  rdata_d[NUM_UNITS-1:0] = status_q;
               end else if (rd_kind == REG_IRQ_ENABLE) begin
                  rdata_d[NUM_UNITS-1:0] = enable_q;
               end else if (rd_kind == REG_MODE) begin
                  rdata_d[`FLD_MODE_LSB +: `FLD_MODE_W] = mode_q[rd_unit];
               end else if (rd_kind == REG_OPA) begin
                  rdata_d = opa_q[rd_unit];
               end else if (rd_kind == REG_OPB) begin
                  rdata_d = opb_q[rd_unit];
               end else if (rd_kind == REG_RESULT) begin
                  rdata_d = result_out[rd_unit];
               end else if (rd_kind == REG_NONE) begin
                  rresp_d = `RESP_DECERR;
               end
            end
         end
         default: begin
            if (rready) begin
               rd_state_d = RD_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q <= RD_IDLE;
         rdata_q <= `RST_WORD;
         rresp_q <= `RESP_OKAY;
      end else begin
         rd_state_q <= rd_state_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign rvalid = (rd_state_q == RD_RESP);
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   mode_default_a: assert property (@(posedge aclk)
      !aresetn |=> mode_q[0] == MODE_ADD && mode_q[NUM_UNITS-1] == MODE_ADD)
      else $error("mode not addition after reset");
   scan_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_en |=> !scan_en ##0 scan_cnt_q == 16'h0000)
      else $error("scan strobe not a single pulse");
   sticky_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ovf_event != '0 |=> (status_q & $past(ovf_event)) == $past(ovf_event))
      else $error("overflow event lost");
endmodule // arith_block
`default_nettype wire

// ### sim/axi_host_model.sv
// Register bus master standing in for the controller that feeds the units
`timescale 1ns/1ns
`default_nettype none
module axi_host_model (
   // Clock
   input wire logic aclk,
   // Write channels
   output logic awvalid,
   input wire logic awready,
   output logic [11:0] awaddr,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   // Read channels
   output logic arvalid,
   input wire logic arready,
   output logic [11:0] araddr,
   input wire logic rvalid,
   output logic rready
);
   initial begin
      awvalid = 1'b0;
      awaddr = 12'h000;
      wvalid = 1'b0;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      bready = 1'b0;
      arvalid = 1'b0;
      araddr = 12'h000;
      rready = 1'b0;
   end
   // Released addresses and write data are inverted, while wstrb is left as driven, so a stale value is never mistaken for a live one
   task automatic write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_open;
      logic w_open;
      aw_open = 1'b1;
      w_open = 1'b1;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      while (aw_open || w_open) begin
         @(posedge aclk);
         if (aw_open && awready) begin
            aw_open = 1'b0;
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (w_open && wready) begin
            w_open = 1'b0;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic read(input logic [11:0] a);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      araddr <= ~a;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
   endtask
endmodule // axi_host_model
`default_nettype wire

// ### sim/tb_arith_block.sv
// Self-checking bench for the bank of signed arithmetic units
`timescale 1ns/1ns
`default_nettype none
`include "arith_params.svh"
module tb_arith_block;
   localparam int SCAN = 4;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [15:0][31:0] result_out;
   logic [15:0] overflow_flag, null_result_flag;
   int mismatches = 0;
   int compares = 0;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [31:0] res_m[16], a_m[16], b_m[16];
   logic [1:0] mode_m[16];
   logic [15:0] ovf_m, stat_m, en_m;
   // Mode, operand A, operand B
   logic [65:0] tbl[15] = '{
      {2'h0, 32'h0000_002A, 32'h0000_03E8}, {2'h0, 32'h7FFF_FFFF, 32'h0000_0001},
      {2'h0, 32'hFFFF_F800, 32'h0000_03E8}, {2'h1, 32'h0000_046E, 32'h0000_002A},
      {2'h1, 32'h8000_0000, 32'h0000_0003}, {2'h1, 32'hFFFF_F000, 32'hFFFF_FC18},
      {2'h2, 32'h0000_000C, 32'h0000_000C}, {2'h2, 32'h000F_426A, 32'h0000_0961},
      {2'h2, 32'hFFFF_FC18, 32'h0000_000A}, {2'h3, 32'h0000_0400, 32'h0000_0023},
      {2'h3, 32'h0000_0400, 32'h0000_0000}, {2'h3, 32'h0000_03E8, 32'hFFFF_FFF6},
      {2'h3, 32'hFFFF_FC18, 32'hFFFF_FFF6}, {2'h3, 32'h0000_000A, 32'h0000_0064},
      {2'h3, 32'h8000_0000, 32'hFFFF_FFFF}};

   always #20 aclk = ~aclk;

   arith_block #(.NUM_UNITS(16), .SCAN_CYCLES(SCAN)) u_dut (
      .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
      .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
      .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .result_out, .overflow_flag,
      .null_result_flag, .irq);
   axi_host_model u_host (
      .aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
      .bready, .arvalid, .arready, .araddr, .rvalid, .rready);

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Responses are matched against notes in the order the requests were made
   always @(posedge aclk) begin
      if (rvalid && rready)
         cmp({rresp, rdata}, rq.pop_front());
      if (bvalid && bready)
         cmp(bresp, bq.pop_front());
   end
   function automatic logic [32:0] calc(input logic [1:0] m, input logic [31:0] a,
                                        input logic [31:0] b, input logic [31:0] p);
      longint x;
      case (m)
         2'h0: x = longint'($signed(a)) + longint'($signed(b));
         2'h1: x = longint'($signed(a)) - longint'($signed(b));
         2'h2: x = longint'($signed(a)) * longint'($signed(b));
         default:
            if (b == 32'h0000_0000)
               x = 64'h0000_0001_0000_0000;
            else
               x = longint'($signed(a)) / longint'($signed(b));
      endcase
      if (x != longint'($signed(x[31:0])))
         return {1'b1, p};
      return {1'b0, x[31:0]};
   endfunction
   function automatic logic [15:0] nul();
      foreach (res_m[i])
         nul[i] = (res_m[i] == 32'h0000_0000);
   endfunction
   function automatic logic [11:0] ua(input int u, input logic [3:0] o);
      return `OFS_UNIT_BASE + 12'(u * 16) + {8'h00, o};
   endfunction
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
      rq.push_back({r, e});
      u_host.read(a);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                     input logic [1:0] r = 2'h0);
      bq.push_back(r);
      u_host.write(a, d, s);
   endtask
   // At least one whole scan passes, so the model sees the state the scan saw
   task automatic step(input int u);
      logic [32:0] c;
      repeat (SCAN + 2) @(posedge aclk);
      c = calc(mode_m[u], a_m[u], b_m[u], res_m[u]);
      ovf_m[u] = c[32];
      res_m[u] = c[31:0];
      stat_m = stat_m | ovf_m;
   endtask
   task automatic run(input int u, input logic [1:0] m, input logic [31:0] a,
                      input logic [31:0] b);
      a_m[u] = a;
      wr(ua(u, `UNIT_OFS_OPA), a);
      step(u);
      b_m[u] = b;
      wr(ua(u, `UNIT_OFS_OPB), b);
      step(u);
      mode_m[u] = m;
      wr(ua(u, `UNIT_OFS_MODE), {30'h0, m});
      step(u);
   endtask
   task automatic chk(input int u);
      rd(ua(u, `UNIT_OFS_RESULT), res_m[u]);
      rd(`OFS_FLAGS, {nul(), ovf_m});
      cmp(result_out[u], res_m[u]);
      cmp({null_result_flag, overflow_flag}, {nul(), ovf_m});
      cmp(irq, |(stat_m & en_m));
   endtask
   task automatic irq_step(input logic [11:0] a, input logic [31:0] d);
      wr(a, d);
      repeat (SCAN + 2) @(posedge aclk);
      if (a == `OFS_IRQ_ENABLE)
         en_m = d[15:0];
      else
         stat_m = ovf_m;
      rd(`OFS_IRQ_STATUS, {16'h0000, stat_m});
      rd(`OFS_IRQ_ENABLE, {16'h0000, en_m});
      cmp(irq, |(stat_m & en_m));
   endtask
   task automatic do_reset(input int n);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (n) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (res_m[i]) begin
         res_m[i] = 32'h0000_0000;
         a_m[i] = 32'h0000_0000;
         b_m[i] = 32'h0000_0000;
         mode_m[i] = 2'h0;
      end
      ovf_m = 16'h0000;
      stat_m = 16'h0000;
      en_m = 16'h0000;
   endtask
   task automatic idle_check();
      for (int u = 0; u < 16; u++) begin
         rd(ua(u, `UNIT_OFS_MODE), 32'h0000_0000);
         chk(u);
      end
      rd(`OFS_IRQ_STATUS, 32'h0000_0000);
      rd(`OFS_IRQ_ENABLE, 32'h0000_0000);
      rd(`OFS_IRQ_CLEAR, 32'h0000_0000);
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge aclk);
      mismatches++;
      final_report();
   end
   initial begin
      void'($urandom(55232));
      do_reset(20);
      idle_check();
      $display("test reset values done");
      foreach (tbl[i]) begin
         run(3, tbl[i][65:64], tbl[i][63:32], tbl[i][31:0]);
         chk(3);
      end
      $display("test worked examples done");
      for (int u = 0; u < 16; u++)
         run(u, 2'($urandom), $urandom, 32'($signed(16'($urandom))));
      for (int u = 0; u < 16; u++)
         chk(u);
      $display("test independent units done");
      run(8, 2'h0, res_m[3], 32'h0000_0001);
      chk(8);
      wr(ua(5, `UNIT_OFS_MODE), 32'h0000_0003, 4'hE);
      repeat (SCAN + 2) @(posedge aclk);
      rd(ua(5, `UNIT_OFS_MODE), {30'h0, mode_m[5]});
      rd(12'h200, 32'h0000_0000, 2'h3);
      wr(12'h200, 32'h1234_5678, 4'hF, 2'h3);
      $display("test bus corners done");
      run(7, 2'h2, 32'h7FFF_FFFF, 32'h0000_0002);
      chk(7);
      irq_step(`OFS_IRQ_ENABLE, 32'h0000_0080);
      irq_step(`OFS_IRQ_CLEAR, 32'h0000_FFFF);
      run(7, 2'h0, 32'h0000_0001, 32'h0000_0002);
      irq_step(`OFS_IRQ_CLEAR, 32'h0000_FFFF);
      chk(7);
      $display("test interrupt done");
      do_reset(3);
      idle_check();
      $display("test second reset done");
      final_report();
   end
endmodule // tb_arith_block
`default_nettype wire
